//--- include/tcs_timer_clock_regs.svh
// Register offsets, field positions, reset values and divider counts.
`ifndef TCS_TIMER_CLOCK_REGS_SVH
`define TCS_TIMER_CLOCK_REGS_SVH
`define TCS_ADDR_TIMER_CONTROL_FLAGS 8'h88
`define TCS_ADDR_CLOCK_CONTROL_FIRST 8'h8E
`define TCS_ADDR_CLOCK_CONTROL_SECOND 8'hA6
`define TCS_PAGE_CLOCK_CONTROL_SECOND 8'h10
`define TCS_RST_TIMER_CONTROL_FLAGS 8'h00
`define TCS_RST_CLOCK_CONTROL_FIRST 8'h00
`define TCS_RST_CLOCK_CONTROL_SECOND 8'h00
`define TCS_FLAGS_STORE_MASK 8'h5F
`define TCS_CLK2_WRITE_MASK 8'h03
`define TCS_T1_OVF_BIT 7
`define TCS_T1_RUN_BIT 6
`define TCS_T0_OVF_BIT 5
`define TCS_T0_RUN_BIT 4
`define TCS_T1_CLOCK_SEL_BIT 3
`define TCS_T0_CLOCK_SEL_BIT 2
`define TCS_T4_HIGH_SEL_BIT 1
`define TCS_T4_LOW_SEL_BIT 0
`define TCS_DIV_12 6'h0C
`define TCS_DIV_4 6'h04
`define TCS_DIV_48 6'h30
`define TCS_EXT_DIV_LAST 3'h7
`endif

//--- include/tcs_pkg.sv
// Types shared by the timer clock select block.
package tcs_pkg;
    typedef enum logic [1:0] {
        TCS_PRE_DIV12 = 2'b00,
        TCS_PRE_DIV4 = 2'b01,
        TCS_PRE_DIV48 = 2'b10,
        TCS_PRE_EXT_DIV8 = 2'b11
    } tcs_prescale_e;
endpackage

//--- include/tcs_presc_if.sv
// Link between the control block and the shared prescaler.
`timescale 1ns/100ps
interface tcs_presc_if;
    tcs_pkg::tcs_prescale_e code;
    logic tick;
    modport ctrl (output code, input tick);
    modport gen (input code, output tick);
endinterface

//--- logic/tcs_prescaler.sv
// Shared prescaler for timers 0 and 1, one-cycle tick output.
`timescale 1ns/100ps
`include "tcs_timer_clock_regs.svh"
module tcs_prescaler (
    input wire logic clk,
    input wire logic rst,
    input wire logic ext_osc,
    tcs_presc_if.gen pif
);
    logic [5:0] div_cnt_r;
    logic [5:0] div_lim;
    logic [2:0] ext_cnt_r;
    logic ext_s1_r;
    logic ext_s2_r;
    logic ext_s3_r;
    logic ext_rise;
    logic div_wrap;
    logic tick_r;

    // Divide ratio for the selected code.
    always_comb
    begin
        unique case (pif.code)
            tcs_pkg::TCS_PRE_DIV12: div_lim = `TCS_DIV_12;
            tcs_pkg::TCS_PRE_DIV4: div_lim = `TCS_DIV_4;
            tcs_pkg::TCS_PRE_DIV48: div_lim = `TCS_DIV_48;
            tcs_pkg::TCS_PRE_EXT_DIV8: div_lim = `TCS_DIV_4;
        endcase
    end

    // Compare with >= so a switch to a shorter ratio never overruns.
    assign div_wrap = div_cnt_r >= (div_lim - 6'h01);

    // System clock divider.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            div_cnt_r <= 6'h00;
        else if (div_wrap)
            div_cnt_r <= 6'h00;
        else
            div_cnt_r <= div_cnt_r + 6'h01;
    end

    // The oscillator is asynchronous, so it passes two flops first.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
        end
        else
        begin
            ext_s1_r <= ext_osc;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end

    assign ext_rise = ext_s2_r & ~ext_s3_r;

    // Counts resynchronised oscillator edges, one tick every eighth.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ext_cnt_r <= 3'h0;
        else if (ext_rise)
            ext_cnt_r <= ext_cnt_r + 3'h1;
    end

    // Registered tick for whichever source the code picks.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            tick_r <= 1'b0;
        else if (pif.code == tcs_pkg::TCS_PRE_EXT_DIV8)
            tick_r <= ext_rise && (ext_cnt_r == `TCS_EXT_DIV_LAST);
        else
            tick_r <= div_wrap;
    end

    assign pif.tick = tick_r;

    // The past-code term skips a tick launched by the previous source.
    chk_div4_period: assert property (@(posedge clk) disable iff (rst)
        (tick_r && pif.code == tcs_pkg::TCS_PRE_DIV4
         && $past(pif.code) == tcs_pkg::TCS_PRE_DIV4
         ##1 (pif.code == tcs_pkg::TCS_PRE_DIV4) [*3]) |=> tick_r)
        else $error("divide by four tick period wrong");
    chk_div12_gap: assert property (@(posedge clk) disable iff (rst)
        (tick_r && pif.code == tcs_pkg::TCS_PRE_DIV12
         && $past(pif.code) == tcs_pkg::TCS_PRE_DIV12
         ##1 (pif.code == tcs_pkg::TCS_PRE_DIV12) [*3]) |-> !tick_r)
        else $error("divide by twelve tick too early");
    chk_ext_tick_cause: assert property (
        @(posedge clk) disable iff (rst)
        (tick_r && pif.code == tcs_pkg::TCS_PRE_EXT_DIV8
         && $past(pif.code) == tcs_pkg::TCS_PRE_EXT_DIV8)
        |-> $past(ext_rise) && $past(ext_cnt_r) == `TCS_EXT_DIV_LAST)
        else $error("oscillator tick without eighth edge");
endmodule

//--- logic/tcs_timer_clock.sv
// Timer 0/1 clock select, run control, overflow flags, timer 4 select.
// Behaviour
// - Timer 0 select: 0 prescaler, 1 system clock; ignored in counter mode.
// - Prescale code gives clock/12, /4, /48, or synchronised oscillator/8.
// - Timer 4 high byte select, split mode only: 0 external field, 1 clock.
// - Timer 4 low byte select for whole or low half: 0 field, 1 clock.
// - Run bits of timers 0 and 1: 1 counts, 0 stops.
// - Second clock register decoded only on page 0x10, address 0xA6.
// - In counter mode a timer counts falling edges of its input pin.
// - With gate on, count needs run bit and active interrupt input.
`timescale 1ns/100ps
`include "tcs_timer_clock_regs.svh"
module tcs_timer_clock (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_PAGE,
    input wire logic SFR_WE,
    input wire logic [7:0] SFR_WDATA,
    output logic [7:0] SFR_RDATA,
    input wire logic EXTERNAL_OSCILLATOR,
    input wire logic [1:0] TIMER_PIN,
    input wire logic EXTERNAL_INTERRUPT_ZERO_INPUT,
    input wire logic EXTERNAL_INTERRUPT_ONE_INPUT,
    input wire logic TIMER_ZERO_COUNTER_SELECT,
    input wire logic TIMER_ONE_COUNTER_SELECT,
    input wire logic TIMER_ZERO_GATE_ENABLE,
    input wire logic TIMER_ONE_GATE_ENABLE,
    input wire logic [1:0] TIMER_OVERFLOW,
    input wire logic [1:0] TIMER_VECTOR,
    input wire logic TIMER_FOUR_SPLIT,
    input wire logic TIMER_FOUR_EXT_TICK,
    output logic [1:0] TIMER_TICK,
    output logic TIMER_FOUR_LOW_TICK,
    output logic TIMER_FOUR_HIGH_TICK,
    output logic TIMER_ZERO_RUN,
    output logic TIMER_ONE_RUN,
    output logic TIMER_ZERO_OVERFLOW_FLAG,
    output logic TIMER_ONE_OVERFLOW_FLAG
);
    logic [7:0] flags_ctrl_r;
    logic [7:0] clk_first_r;
    logic [7:0] clk_second_r;
    logic [1:0] ovf_flag_r;
    logic [7:0] rdata_nxt;
    logic [7:0] rdata_r;
    logic [1:0] pin_d_r;
    logic [1:0] tick_r;
    logic t4_low_r;
    logic t4_high_r;
    logic wr_flags;
    logic wr_ck0;
    logic wr_ck1;
    logic [1:0] run;
    logic [1:0] gate;
    logic [1:0] cnt_sel;
    logic [1:0] int_act;
    logic [1:0] clk_sel;
    logic [1:0] flag_bit;
    tcs_presc_if pif ();

    // Page 0 lookup covers registers present on every page.
    function automatic logic sfr_hit(input logic [7:0] addr,
                                     input logic [7:0] page,
                                     input logic [7:0] want,
                                     input logic all_pages,
                                     input logic [7:0] want_page);
        sfr_hit = (addr == want) && (all_pages || page == want_page);
    endfunction

    // Write decode for the three registers.
    assign wr_flags = SFR_WE && sfr_hit(SFR_ADDR, SFR_PAGE,
        `TCS_ADDR_TIMER_CONTROL_FLAGS, 1'b1, 8'h00);
    assign wr_ck0 = SFR_WE && sfr_hit(SFR_ADDR, SFR_PAGE,
        `TCS_ADDR_CLOCK_CONTROL_FIRST, 1'b1, 8'h00);
    assign wr_ck1 = SFR_WE && sfr_hit(SFR_ADDR, SFR_PAGE,
        `TCS_ADDR_CLOCK_CONTROL_SECOND, 1'b0,
        `TCS_PAGE_CLOCK_CONTROL_SECOND);

    // Control bits; the flag bits live in their own flops below.
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            flags_ctrl_r <= `TCS_RST_TIMER_CONTROL_FLAGS;
        else if (wr_flags)
            flags_ctrl_r <= SFR_WDATA & `TCS_FLAGS_STORE_MASK;
    end

    // Upper bits serve the other timers and are only stored here.
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            clk_first_r <= `TCS_RST_CLOCK_CONTROL_FIRST;
        else if (wr_ck0)
            clk_first_r <= SFR_WDATA;
    end

    // Reserved upper bits never store, so they always read as reset.
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            clk_second_r <= `TCS_RST_CLOCK_CONTROL_SECOND;
        else if (wr_ck1)
            clk_second_r <= SFR_WDATA & `TCS_CLK2_WRITE_MASK;
    end

    assign run = {flags_ctrl_r[`TCS_T1_RUN_BIT],
                  flags_ctrl_r[`TCS_T0_RUN_BIT]};
    assign gate = {TIMER_ONE_GATE_ENABLE, TIMER_ZERO_GATE_ENABLE};
    assign cnt_sel = {TIMER_ONE_COUNTER_SELECT, TIMER_ZERO_COUNTER_SELECT};
    assign int_act = {EXTERNAL_INTERRUPT_ONE_INPUT,
                      EXTERNAL_INTERRUPT_ZERO_INPUT};
    assign clk_sel = {clk_first_r[`TCS_T1_CLOCK_SEL_BIT],
                      clk_first_r[`TCS_T0_CLOCK_SEL_BIT]};
    assign flag_bit = {SFR_WDATA[`TCS_T1_OVF_BIT],
                       SFR_WDATA[`TCS_T0_OVF_BIT]};
    assign pif.code = tcs_pkg::tcs_prescale_e'(clk_first_r[1:0]);

    tcs_prescaler u_prescaler (
        .clk(MCLK),
        .rst(RST),
        .ext_osc(EXTERNAL_OSCILLATOR),
        .pif(pif)
    );

    // Per-timer count enables and overflow flags for timers 0 and 1.
    for (genvar i = 0; i < 2; i++)
    begin : g_tmr
        // Pin history for falling edge detection.
        always_ff @(posedge MCLK or posedge RST)
        begin
            if (RST)
                pin_d_r[i] <= 1'b0;
            else
                pin_d_r[i] <= TIMER_PIN[i];
        end

        // Run and gate first, then the source picks the tick.
        always_ff @(posedge MCLK or posedge RST)
        begin
            if (RST)
                tick_r[i] <= 1'b0;
            else if (!run[i] || (gate[i] && !int_act[i]))
                tick_r[i] <= 1'b0;
            else if (cnt_sel[i])
                tick_r[i] <= pin_d_r[i] & ~TIMER_PIN[i];
            else if (clk_sel[i])
                tick_r[i] <= 1'b1;
            else
                tick_r[i] <= pif.tick;
        end

        // A new overflow beats a clear in the same cycle.
        always_ff @(posedge MCLK or posedge RST)
        begin
            if (RST)
                ovf_flag_r[i] <= 1'b0;
            else if (TIMER_OVERFLOW[i])
                ovf_flag_r[i] <= 1'b1;
            else if (TIMER_VECTOR[i])
                ovf_flag_r[i] <= 1'b0;
            else if (wr_flags)
                ovf_flag_r[i] <= flag_bit[i];
        end
    end

    // Timer 4 byte clocks; the high byte runs only when split.
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            t4_low_r <= 1'b0;
            t4_high_r <= 1'b0;
        end
        else
        begin
            t4_low_r <= clk_second_r[`TCS_T4_LOW_SEL_BIT]
                | TIMER_FOUR_EXT_TICK;
            t4_high_r <= TIMER_FOUR_SPLIT &&
                (clk_second_r[`TCS_T4_HIGH_SEL_BIT] | TIMER_FOUR_EXT_TICK);
        end
    end

    // Read mux; unmapped addresses read zero.
    always_comb
    begin
        rdata_nxt = 8'h00;
        if (sfr_hit(SFR_ADDR, SFR_PAGE, `TCS_ADDR_TIMER_CONTROL_FLAGS,
                    1'b1, 8'h00))
        begin
            rdata_nxt = flags_ctrl_r;
            rdata_nxt[`TCS_T1_OVF_BIT] = ovf_flag_r[1];
            rdata_nxt[`TCS_T0_OVF_BIT] = ovf_flag_r[0];
        end
        else if (sfr_hit(SFR_ADDR, SFR_PAGE, `TCS_ADDR_CLOCK_CONTROL_FIRST,
                         1'b1, 8'h00))
            rdata_nxt = clk_first_r;
        else if (sfr_hit(SFR_ADDR, SFR_PAGE,
                         `TCS_ADDR_CLOCK_CONTROL_SECOND, 1'b0,
                         `TCS_PAGE_CLOCK_CONTROL_SECOND))
            rdata_nxt = clk_second_r;
    end

    // Read data is registered, one cycle behind the address.
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            rdata_r <= 8'h00;
        else
            rdata_r <= rdata_nxt;
    end

    assign SFR_RDATA = rdata_r;
    assign TIMER_TICK = tick_r;
    assign TIMER_FOUR_LOW_TICK = t4_low_r;
    assign TIMER_FOUR_HIGH_TICK = t4_high_r;
    assign TIMER_ZERO_RUN = flags_ctrl_r[`TCS_T0_RUN_BIT];
    assign TIMER_ONE_RUN = flags_ctrl_r[`TCS_T1_RUN_BIT];
    assign TIMER_ZERO_OVERFLOW_FLAG = ovf_flag_r[0];
    assign TIMER_ONE_OVERFLOW_FLAG = ovf_flag_r[1];

    chk_t1_sysclk_tick: assert property (
        @(posedge MCLK) disable iff (RST)
        (run[1] && !gate[1] && !cnt_sel[1] && clk_sel[1]) |=> tick_r[1])
        else $error("timer 1 system clock tick missing");
    chk_t0_prescale_tick: assert property (
        @(posedge MCLK) disable iff (RST)
        (run[0] && !gate[0] && !cnt_sel[0] && !clk_sel[0])
        |=> tick_r[0] == $past(pif.tick))
        else $error("timer 0 not following prescaler");
    chk_t4_high_split: assert property (
        @(posedge MCLK) disable iff (RST)
        !TIMER_FOUR_SPLIT |=> !t4_high_r)
        else $error("timer 4 high byte clocked outside split");
    chk_t4_low_sys: assert property (
        @(posedge MCLK) disable iff (RST)
        clk_second_r[`TCS_T4_LOW_SEL_BIT] |=> t4_low_r)
        else $error("timer 4 low byte missed system clock");
    chk_run_stops: assert property (
        @(posedge MCLK) disable iff (RST)
        (!run[0] ##1 !run[0]) |-> !tick_r[0])
        else $error("timer 0 ticked while stopped");
    chk_page_gate: assert property (
        @(posedge MCLK) disable iff (RST)
        (SFR_WE && SFR_ADDR == `TCS_ADDR_CLOCK_CONTROL_SECOND
         && SFR_PAGE != `TCS_PAGE_CLOCK_CONTROL_SECOND)
        |=> $stable(clk_second_r))
        else $error("second clock register written on wrong page");
    chk_reserved_zero: assert property (
        @(posedge MCLK) disable iff (RST)
        clk_second_r[7:2] == 6'h00)
        else $error("reserved clock bits not at reset value");
    chk_ovf_sets: assert property (
        @(posedge MCLK) disable iff (RST)
        TIMER_OVERFLOW[1] |=> ovf_flag_r[1] [*1])
        else $error("timer 1 overflow flag not set");
    chk_vector_clears: assert property (
        @(posedge MCLK) disable iff (RST)
        (TIMER_VECTOR[0] && !TIMER_OVERFLOW[0]) |=> !ovf_flag_r[0])
        else $error("timer 0 flag not cleared on vectoring");
    chk_counter_edge: assert property (
        @(posedge MCLK) disable iff (RST)
        (tick_r[1] && $past(cnt_sel[1]))
        |-> $past(pin_d_r[1]) && !$past(TIMER_PIN[1]))
        else $error("timer 1 counted without falling edge");
    chk_gate_blocks: assert property (
        @(posedge MCLK) disable iff (RST)
        (gate[0] && !int_act[0]) |=> !tick_r[0])
        else $error("timer 0 counted with gate closed");
endmodule

//--- test/tcs_timer_clock_bench.sv
// Self-checking bench for the timer clock select and run control block.
`timescale 1ns/100ps
module tcs_timer_clock_bench;
    logic mclk;
    logic rst;
    logic [7:0] addr;
    logic [7:0] page;
    logic we;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic osc;
    logic osc_en;
    logic [1:0] pin;
    logic external_interrupt_zero_input;
    logic int1;
    logic cs0;
    logic cs1;
    logic g0;
    logic g1;
    logic [1:0] ovf;
    logic [1:0] vec;
    logic split;
    logic ext_tick;
    logic [1:0] tick;
    logic t4_low;
    logic t4_high;
    logic run0;
    logic run1;
    logic flag0;
    logic flag1;
    logic exp_low;
    logic exp_high;
    int fails;
    int comparisons;
    int seed;
    int c0;
    int c1;
    int n;
    int divs[3] = '{12, 4, 48};

    tcs_timer_clock i_dut (
        .MCLK(mclk), .RST(rst), .SFR_ADDR(addr), .SFR_PAGE(page),
        .SFR_WE(we), .SFR_WDATA(wdata), .SFR_RDATA(rdata),
        .EXTERNAL_OSCILLATOR(osc), .TIMER_PIN(pin),
        .EXTERNAL_INTERRUPT_ZERO_INPUT(external_interrupt_zero_input),
        .EXTERNAL_INTERRUPT_ONE_INPUT(int1),
        .TIMER_ZERO_COUNTER_SELECT(cs0), .TIMER_ONE_COUNTER_SELECT(cs1),
        .TIMER_ZERO_GATE_ENABLE(g0), .TIMER_ONE_GATE_ENABLE(g1),
        .TIMER_OVERFLOW(ovf), .TIMER_VECTOR(vec),
        .TIMER_FOUR_SPLIT(split), .TIMER_FOUR_EXT_TICK(ext_tick),
        .TIMER_TICK(tick), .TIMER_FOUR_LOW_TICK(t4_low),
        .TIMER_FOUR_HIGH_TICK(t4_high), .TIMER_ZERO_RUN(run0),
        .TIMER_ONE_RUN(run1), .TIMER_ZERO_OVERFLOW_FLAG(flag0),
        .TIMER_ONE_OVERFLOW_FLAG(flag1)
    );

    // Free-running system clock, 8 ns period.
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // Slow oscillator, six cycles a period, so each level is seen safely.
    initial
    begin
        osc = 1'b0;
        forever
        begin
            repeat (3) @(negedge mclk);
            if (osc_en)
                osc <= ~osc;
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic sfr_write(input logic [7:0] a, input logic [7:0] p,
                             input logic [7:0] d);
        @(negedge mclk);
        addr = a;
        page = p;
        wdata = d;
        we = 1'b1;
        @(negedge mclk);
        we = 1'b0;
    endtask

    // Read data is registered, so it is sampled one cycle after the address.
    task automatic sfr_read(input logic [7:0] a, input logic [7:0] p,
                            input logic [7:0] exp);
        @(negedge mclk);
        addr = a;
        page = p;
        @(negedge mclk);
        check(rdata, exp);
    endtask

    // Settle first; windows are whole multiples of every divider period.
    task automatic count_ticks(input int len);
        repeat (60) @(negedge mclk);
        c0 = 0;
        c1 = 0;
        repeat (len)
        begin
            @(negedge mclk);
            c0 += int'(tick[0] === 1'b1);
            c1 += int'(tick[1] === 1'b1);
        end
    endtask

    task automatic give_verdict;
        $display("Mismatches %0d, comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // A hung handshake would otherwise stall the run for ever.
    initial
    begin
        #100000;
        fails++;
        give_verdict();
    end

    // Main sequence.
    initial
    begin
        {addr, page, wdata, we, osc_en, pin, external_interrupt_zero_input, int1} = '0;
        {cs0, cs1, g0, g1, ovf, vec, split, ext_tick} = '0;
        fails = 0;
        comparisons = 0;
        seed = 32'h4A8B;
        rst = 1'b1;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        sfr_read(8'h88, 8'h00, 8'h00);
        sfr_read(8'h8E, 8'h00, 8'h00);
        sfr_read(8'hA6, 8'h10, 8'h00);
        sfr_write(8'h88, 8'h00, 8'h5A);
        sfr_read(8'h88, 8'h00, 8'h5A);
        check({6'h00, run1, run0}, 8'h03);
        sfr_write(8'hA6, 8'h00, 8'hFF);
        sfr_read(8'hA6, 8'h10, 8'h00);
        sfr_read(8'hA6, 8'h00, 8'h00);
        sfr_write(8'hA6, 8'h10, 8'hFF);
        sfr_read(8'hA6, 8'h10, 8'h03);
        // Each system clock prescaler code with one timer on it and the other on clock.
        for (int code = 0; code < 3; code++)
        begin
            sfr_write(8'h8E, 8'h00, 8'h04 | 8'(code));
            count_ticks(96);
            check(8'(c0), 8'(96));
            check(8'(c1), 8'(96 / divs[code]));
            sfr_write(8'h8E, 8'h00, 8'h08 | 8'(code));
            count_ticks(96);
            check(8'(c0), 8'(96 / divs[code]));
            check(8'(c1), 8'(96));
        end
        osc_en = 1'b1;
        sfr_write(8'h8E, 8'h00, 8'h03);
        count_ticks(96);
        check(8'(c0), 8'(2));
        check(8'(c1), 8'(2));
        sfr_write(8'h8E, 8'h00, 8'h0C);
        sfr_write(8'h88, 8'h00, 8'h00);
        count_ticks(48);
        check(8'(c0 + c1), 8'(0));
        sfr_write(8'h88, 8'h00, 8'h50);
        // Gated counting follows the interrupt input of each timer.
        g0 = 1'b1;
        g1 = 1'b1;
        int1 = 1'b1;
        count_ticks(96);
        check(8'(c0), 8'(0));
        check(8'(c1), 8'(96));
        external_interrupt_zero_input = 1'b1;
        int1 = 1'b0;
        count_ticks(96);
        check(8'(c0), 8'(96));
        check(8'(c1), 8'(0));
        g0 = 1'b0;
        g1 = 1'b0;
        // Counter mode counts falling pin edges, clock select ignored.
        cs0 = 1'b1;
        cs1 = 1'b1;
        pin = 2'b11;
        n = ($random(seed) & 32'h7) + 3;
        c0 = 0;
        c1 = 0;
        for (int k = 0; k < n * 4 + 8; k++)
        begin
            @(negedge mclk);
            c0 += int'(tick[0] === 1'b1);
            c1 += int'(tick[1] === 1'b1);
            pin <= (k < n * 4 && k % 4 < 2) ? 2'b00 : 2'b11;
        end
        check(8'(c0), 8'(n));
        check(8'(c1), 8'(n));
        cs0 = 1'b0;
        cs1 = 1'b0;
        // Overflow sets, vectoring and firmware clear; set beats vector.
        @(negedge mclk);
        ovf = 2'b01;
        @(negedge mclk);
        ovf = 2'b00;
        check({6'h00, flag1, flag0}, 8'h01);
        sfr_read(8'h88, 8'h00, 8'h70);
        vec = 2'b01;
        @(negedge mclk);
        vec = 2'b00;
        check({6'h00, flag1, flag0}, 8'h00);
        ovf = 2'b10;
        vec = 2'b10;
        @(negedge mclk);
        {ovf, vec} = '0;
        check({6'h00, flag1, flag0}, 8'h02);
        sfr_write(8'h88, 8'h00, 8'h50);
        check({6'h00, flag1, flag0}, 8'h00);
        // Timer 4 byte clocks against a one-cycle-late model.
        for (int s = 0; s < 4; s++)
        begin
            sfr_write(8'hA6, 8'h10, 8'(s));
            for (int k = 0; k < 16; k++)
            begin
                @(negedge mclk);
                if (k > 0)
                begin
                    check({7'h00, t4_low}, {7'h00, exp_low});
                    check({7'h00, t4_high}, {7'h00, exp_high});
                end
                split = 1'($random(seed));
                ext_tick = 1'($random(seed));
                exp_low = s[0] | ext_tick;
                exp_high = split & (s[1] | ext_tick);
            end
        end
        give_verdict();
    end
endmodule
